// ### hdl/dual_dac_defs.svh
`ifndef DUAL_DAC_DEFS_SVH
`define DUAL_DAC_DEFS_SVH

// Register offsets
`define OFS_CH0_CODE 6'h10
`define OFS_CH1_CODE 6'h12
`define OFS_UPDATE 6'h18
`define OFS_OUT_CLEAR 6'h1E
`define OFS_CTRL 6'h20
`define OFS_STATUS 6'h22
`define OFS_MASK 6'h24
`define OFS_FIFO_LEVEL 6'h26

// Control field positions
`define CTRL_MODE_LSB 0
`define CTRL_POSTED_BIT 2
`define CTRL_BIPOLAR0_BIT 3
`define CTRL_BIPOLAR1_BIT 4
`define CTRL_TWOS0_BIT 5
`define CTRL_TWOS1_BIT 6
`define CTRL_RESET 7'h00

// Status field positions
`define STAT_UPDREQ_BIT 0
`define STAT_COMPLETE_BIT 1
`define STAT_OVFL_BIT 2

// Data word layout
`define CODE_MSB 11
`define FULL_SCALE 12'hFFF
`define BIP_MAX 12'h7FF

// FIFO
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

// ### hdl/dual_dac_pkg.sv
package dual_dac_pkg;

    typedef enum logic [1:0] {
        PATH_DIRECT = 2'b00,
        PATH_FIFO = 2'b01,
        PATH_SERIAL = 2'b11
    } path_t;

    typedef struct packed {
        logic twos1;
        logic twos0;
        logic bipolar1;
        logic bipolar0;
        logic posted;
        path_t path;
    } ctrl_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic chan;
        logic [11:0] code;
    } fifo_word_t;

endpackage : dual_dac_pkg

// ### hdl/dac_word_fifo.sv
`timescale 1ns/1ns
`default_nettype none
`include "dual_dac_defs.svh"

module dac_word_fifo (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic flush,
    input wire logic push_valid,
    output logic push_ready,
    input wire dual_dac_pkg::fifo_word_t push_data,
    output logic pop_valid,
    input wire logic pop_ready,
    output dual_dac_pkg::fifo_word_t pop_data,
    output logic [`FIFO_AW:0] level
);
    dual_dac_pkg::fifo_word_t mem_r [`FIFO_DEPTH];
    logic [`FIFO_AW-1:0] wp_r;
    logic [`FIFO_AW-1:0] rp_r;
    logic [`FIFO_AW:0] cnt_r;
    logic do_push;
    logic do_pop;

    assign push_ready = (cnt_r != `FIFO_DEPTH);
    assign pop_valid = (cnt_r != '0);
    assign pop_data = mem_r[rp_r];
    assign level = cnt_r;
    // A push into a full queue is dropped, held words stay intact
    assign do_push = push_valid && push_ready && !flush;
    assign do_pop = pop_valid && pop_ready && !flush;

    always_ff @(posedge mclk) begin
        if (ce && do_push) begin
            mem_r[wp_r] <= push_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            if (flush) begin
                wp_r <= '0;
                rp_r <= '0;
                cnt_r <= '0;
            end else begin
                if (do_push) begin
                    wp_r <= wp_r + 1'b1;
                end
                if (do_pop) begin
                    rp_r <= rp_r + 1'b1;
                end
                cnt_r <= cnt_r + {{`FIFO_AW{1'b0}}, do_push} - {{`FIFO_AW{1'b0}}, do_pop};
            end
        end
    end
endmodule : dac_word_fifo

`default_nettype wire

// ### hdl/dual_dac_write_update_control.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "dual_dac_defs.svh"

// Functional notes
// - Control path field picks direct bus, queued, or serial companion data.
// - Immediate mode drives a written code to its converter at once.
// - Posted mode applies held codes on trigger falling edge or update strobe.
// - Queue used only in posted mode with the queued path, bypassed otherwise.
// - Per-channel bits select unipolar/bipolar and binary/two's complement.
// - Unipolar code is unsigned 0 to 0FFF.
// - Bipolar two's complement code is signed, 07FF largest positive.
// - Write at 10 hex is channel 0 data; immediate loads converter 0.
// - Posted channel 0 value held until update strobe or trigger.
// - Code taken from bits 11..0, bits 15..12 ignored.
// - Channel 0 straight binary unipolar, two's complement bipolar.
// - Write at 12 hex is channel 1 data; immediate loads converter 1.
// - Posted channel 1 value held until update strobe or trigger.
// - Channel 1 straight binary unipolar, two's complement bipolar.
// - Posted write at 18 hex updates both converters, or applies one queued word in queued mode.
// - Posted trigger falling edge updates and sets update request flag.
// - Access at 1E hex empties queue, clears request and complete flags.
module dual_dac_write_update_control (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [5:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic timer_update_trigger_n,
    input wire logic serial_valid,
    input wire logic serial_chan,
    input wire logic [11:0] serial_code,
    output logic [11:0] output_channel0,
    output logic [11:0] output_channel1,
    output logic output_channel0_load,
    output logic output_channel1_load,
    output logic [11:0] output_channel0_offset_bin,
    output logic [11:0] output_channel1_offset_bin,
    output logic irq
);
    dual_dac_pkg::bus_req_t req;
    dual_dac_pkg::ctrl_t ctrl_r;
    dual_dac_pkg::fifo_word_t fifo_in;
    dual_dac_pkg::fifo_word_t fifo_out;
    logic [11:0] hold0_r;
    logic [11:0] hold1_r;
    logic [11:0] code_w;
    logic [2:0] status_r;
    logic [2:0] mask_r;
    logic [2:0] stat_set;
    logic trig_s1_r;
    logic trig_s2_r;
    logic trig_prev_r;
    logic trig_fall;
    logic wr_ch0;
    logic wr_ch1;
    logic upd_strobe;
    logic clr_strobe;
    logic use_fifo;
    logic update_now;
    logic fifo_ready;
    logic fifo_valid;
    logic fifo_pop;
    logic [`FIFO_AW:0] fifo_level;
    logic [11:0] ser_code_r;
    logic ser_chan_r;
    logic [11:0] ser_code_s1_r;
    logic ser_chan_s1_r;
    logic ser_v_s1_r;
    logic ser_v_s2_r;
    logic ser_v_prev_r;
    logic ser_take;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign code_w = req.wdata[`CODE_MSB:0];
    assign wr_ch0 = req.wr && (req.addr == `OFS_CH0_CODE);
    assign wr_ch1 = req.wr && (req.addr == `OFS_CH1_CODE);
    assign upd_strobe = req.wr && (req.addr == `OFS_UPDATE) && ctrl_r.posted;
    // Clear acts on a read or a write, as either access is a strobe
    assign clr_strobe = (req.wr || req.rd) && (req.addr == `OFS_OUT_CLEAR);
    // Queue only when posted and the queued path is chosen
    assign use_fifo = ctrl_r.posted && (ctrl_r.path == dual_dac_pkg::PATH_FIFO);
    assign trig_fall = trig_prev_r && !trig_s2_r;
    assign update_now = ctrl_r.posted && (trig_fall || upd_strobe);
    assign fifo_in = '{chan: wr_ch1, code: code_w};
    assign fifo_pop = update_now && fifo_valid;
    assign ser_take = ser_v_s2_r && !ser_v_prev_r
        && (ctrl_r.path == dual_dac_pkg::PATH_SERIAL);

    dac_word_fifo u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .flush(clr_strobe),
        .push_valid(use_fifo && (wr_ch0 || wr_ch1)),
        .push_ready(fifo_ready),
        .push_data(fifo_in),
        .pop_valid(fifo_valid),
        .pop_ready(update_now),
        .pop_data(fifo_out),
        .level(fifo_level)
    );

    // Trigger and serial strobe are pins: two stages before use
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            trig_s1_r <= 1'b1;
            trig_s2_r <= 1'b1;
            trig_prev_r <= 1'b1;
            ser_v_s1_r <= 1'b0;
            ser_v_s2_r <= 1'b0;
            ser_v_prev_r <= 1'b0;
        end else if (ce) begin
            trig_s1_r <= timer_update_trigger_n;
            trig_s2_r <= trig_s1_r;
            trig_prev_r <= trig_s2_r;
            ser_v_s1_r <= serial_valid;
            ser_v_s2_r <= ser_v_s1_r;
            ser_v_prev_r <= ser_v_s2_r;
        end
    end

    // Serial word and channel are pins too; they stay steady while the strobe is high,
    // so after two stages they line up with the synchronised strobe edge
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ser_code_s1_r <= 12'h000;
            ser_code_r <= 12'h000;
            ser_chan_s1_r <= 1'b0;
            ser_chan_r <= 1'b0;
        end else if (ce) begin
            ser_code_s1_r <= serial_code;
            ser_code_r <= ser_code_s1_r;
            ser_chan_s1_r <= serial_chan;
            ser_chan_r <= ser_chan_s1_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_r <= dual_dac_pkg::ctrl_t'(`CTRL_RESET);
            mask_r <= 3'h0;
        end else if (ce && req.wr) begin
            if (req.addr == `OFS_CTRL) begin
                ctrl_r <= dual_dac_pkg::ctrl_t'(req.wdata[6:0]);
            end
            if (req.addr == `OFS_MASK) begin
                mask_r <= req.wdata[2:0];
            end
        end
    end

    // Holding registers: the value a posted update will apply
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hold0_r <= 12'h000;
            hold1_r <= 12'h000;
        end else if (ce) begin
            if (ser_take && !ser_chan_r) begin
                hold0_r <= ser_code_r;
            end else if (wr_ch0 && !use_fifo && ctrl_r.path != dual_dac_pkg::PATH_SERIAL) begin
                hold0_r <= code_w;
            end
            if (ser_take && ser_chan_r) begin
                hold1_r <= ser_code_r;
            end else if (wr_ch1 && !use_fifo && ctrl_r.path != dual_dac_pkg::PATH_SERIAL) begin
                hold1_r <= code_w;
            end
        end
    end

    // Converter codes; the load pulse tells the converter to latch
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            output_channel0 <= 12'h000;
            output_channel1 <= 12'h000;
            output_channel0_load <= 1'b0;
            output_channel1_load <= 1'b0;
        end else if (ce) begin
            output_channel0_load <= 1'b0;
            output_channel1_load <= 1'b0;
            if (!ctrl_r.posted) begin
                // Immediate mode bypasses the queue whichever bus path is chosen
                if (wr_ch0 && ctrl_r.path != dual_dac_pkg::PATH_SERIAL) begin
                    output_channel0 <= code_w;
                    output_channel0_load <= 1'b1;
                end else if (ser_take && !ser_chan_r) begin
                    output_channel0 <= ser_code_r;
                    output_channel0_load <= 1'b1;
                end
                if (wr_ch1 && ctrl_r.path != dual_dac_pkg::PATH_SERIAL) begin
                    output_channel1 <= code_w;
                    output_channel1_load <= 1'b1;
                end else if (ser_take && ser_chan_r) begin
                    output_channel1 <= ser_code_r;
                    output_channel1_load <= 1'b1;
                end
            end else if (update_now) begin
                // One queued word is applied per update event
                if (use_fifo) begin
                    if (fifo_valid && !fifo_out.chan) begin
                        output_channel0 <= fifo_out.code;
                        output_channel0_load <= 1'b1;
                    end
                    if (fifo_valid && fifo_out.chan) begin
                        output_channel1 <= fifo_out.code;
                        output_channel1_load <= 1'b1;
                    end
                end else begin
                    output_channel0 <= hold0_r;
                    output_channel1 <= hold1_r;
                    output_channel0_load <= 1'b1;
                    output_channel1_load <= 1'b1;
                end
            end
        end
    end

    // Offset-binary view: bipolar two's complement flips the sign bit
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            output_channel0_offset_bin <= 12'h000;
            output_channel1_offset_bin <= 12'h000;
        end else if (ce) begin
            output_channel0_offset_bin <= output_channel0
                ^ {(ctrl_r.bipolar0 && ctrl_r.twos0), 11'h000};
            output_channel1_offset_bin <= output_channel1
                ^ {(ctrl_r.bipolar1 && ctrl_r.twos1), 11'h000};
        end
    end

    assign stat_set = {use_fifo && (wr_ch0 || wr_ch1) && !fifo_ready,
        use_fifo && fifo_pop && (fifo_level == 1), // Last queued word applied
        ctrl_r.posted && (trig_fall || upd_strobe)};

    // Set wins over either clear, so no event is lost; the clear strobe keeps overflow
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            status_r <= 3'h0;
        end else if (ce) begin
            if (clr_strobe) begin
                status_r <= (status_r & 3'h4) | stat_set;
            end else if (req.wr && req.addr == `OFS_STATUS) begin
                status_r <= (status_r & ~req.wdata[2:0]) | stat_set;
            end else begin
                status_r <= status_r | stat_set;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(status_r & mask_r);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata <= 16'h0000;
        end else if (ce) begin
            rdata <= 16'h0000;
            if (req.rd) begin
                case (req.addr)
                    `OFS_CTRL: rdata <= {9'h000, ctrl_r};
                    `OFS_STATUS: rdata <= {13'h0000, status_r};
                    `OFS_MASK: rdata <= {13'h0000, mask_r};
                    `OFS_FIFO_LEVEL: rdata <= {{(15-`FIFO_AW){1'b0}}, fifo_level};
                    default: rdata <= 16'h0000;
                endcase
            end
        end
    end

    chk_imm_load: assert property (@(posedge mclk) disable iff (sys_rst)
        ce && !ctrl_r.posted && ctrl_r.path == dual_dac_pkg::PATH_DIRECT && wr_ch0
        |=> output_channel0 == $past(code_w) && output_channel0_load)
        else $error("immediate write did not load channel 0");

    chk_posted_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        ce && ctrl_r.posted && !update_now |=> !output_channel0_load && !output_channel1_load)
        else $error("posted channel changed without update");

    chk_strobe_both: assert property (@(posedge mclk) disable iff (sys_rst)
        ce && upd_strobe && !use_fifo |=> output_channel0_load && output_channel1_load)
        else $error("update strobe did not load both");

    // Synchronised falling trigger edge while updates are posted
    sequence posted_trig_s;
        ce && ctrl_r.posted && trig_fall;
    endsequence

    chk_trig_load: assert property (@(posedge mclk) disable iff (sys_rst)
        posted_trig_s ##0 !use_fifo
        |=> output_channel0_load && output_channel1_load)
        else $error("trigger edge did not load both channels");

    chk_trig_flag: assert property (@(posedge mclk) disable iff (sys_rst)
        posted_trig_s |=> status_r[`STAT_UPDREQ_BIT])
        else $error("trigger edge did not set request flag");

    chk_clear_flags: assert property (@(posedge mclk) disable iff (sys_rst)
        ce && clr_strobe && !trig_fall |=> status_r[1:0] == 2'b00 && fifo_level == 0)
        else $error("clear strobe left flags or queue");

    chk_full_drop: assert property (@(posedge mclk) disable iff (sys_rst)
        ce && use_fifo && (wr_ch0 || wr_ch1) && fifo_level == `FIFO_DEPTH && !fifo_pop
        |=> fifo_level == `FIFO_DEPTH && status_r[`STAT_OVFL_BIT])
        else $error("write into full queue not dropped");

    chk_hold_ch1: assert property (@(posedge mclk) disable iff (sys_rst)
        ce && wr_ch1 && ctrl_r.posted && ctrl_r.path == dual_dac_pkg::PATH_DIRECT
        |=> hold1_r == $past(code_w))
        else $error("channel 1 holding register not written");

    chk_irq_level: assert property (@(posedge mclk) disable iff (sys_rst)
        ce && |(status_r & mask_r) ##1 ce |-> irq)
        else $error("interrupt not raised for unmasked flag");

    chk_hold_ch0: assert property (@(posedge mclk) disable iff (sys_rst)
        ce && wr_ch0 && ctrl_r.posted && ctrl_r.path == dual_dac_pkg::PATH_DIRECT
        |=> hold0_r == $past(code_w))
        else $error("channel 0 holding register not written");

    chk_serial_load: assert property (@(posedge mclk) disable iff (sys_rst)
        ce && !ctrl_r.posted && ser_take && ser_chan_r
        |=> output_channel1 == $past(ser_code_r) && output_channel1_load)
        else $error("serial word did not load channel 1");

    chk_imm_bypass: assert property (@(posedge mclk) disable iff (sys_rst)
        ce && !use_fifo && (wr_ch0 || wr_ch1) && !fifo_pop
        |=> fifo_level == $past(fifo_level))
        else $error("queue changed outside queued mode");

    chk_offset_ch0: assert property (@(posedge mclk) disable iff (sys_rst)
        ce |=> output_channel0_offset_bin == ($past(output_channel0)
            ^ {($past(ctrl_r.bipolar0) && $past(ctrl_r.twos0)), 11'h000}))
        else $error("channel 0 offset binary view wrong");

    chk_offset_ch1: assert property (@(posedge mclk) disable iff (sys_rst)
        ce |=> output_channel1_offset_bin == ($past(output_channel1)
            ^ {($past(ctrl_r.bipolar1) && $past(ctrl_r.twos1)), 11'h000}))
        else $error("channel 1 offset binary view wrong");

    chk_reset_clear: assert property (@(posedge mclk)
        sys_rst |=> output_channel0 == 12'h000 && output_channel1 == 12'h000
            && hold0_r == 12'h000 && hold1_r == 12'h000 && !ctrl_r.posted)
        else $error("reset left a code or posted mode");
endmodule : dual_dac_write_update_control

`default_nettype wire

// ### dv/dac_sink_model.sv
`timescale 1ns/1ns
`default_nettype none

module dac_sink_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [11:0] code,
    output var logic [11:0] held,
    output var int loads
);
    // A real converter latches only on its load pulse, so the code lines are ignored otherwise
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            held <= 12'h000;
            loads <= 0;
        end else if (load) begin
            held <= code;
            loads <= loads + 1;
        end
    end
endmodule : dac_sink_model

`default_nettype wire

// ### dv/dual_dac_write_update_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "dual_dac_defs.svh"

module dual_dac_write_update_control_tb_top;
    logic mclk, sys_rst, ce, wr, rd, trig_n, ser_valid, ser_chan, irq, ld0, ld1;
    logic [5:0] addr;
    logic [15:0] wdata, rdata, rv;
    logic [11:0] ser_code, ch0, ch1, ob0, ob1, held0, held1;
    int loads0, loads1, err_count, samples_checked;
    dual_dac_pkg::ctrl_t c;
    logic [11:0] codes [4] = '{12'h000, 12'h7FF, 12'h800, 12'hFFF};

    dual_dac_write_update_control i_dut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .timer_update_trigger_n(trig_n), .serial_valid(ser_valid), .serial_chan(ser_chan),
        .serial_code(ser_code), .output_channel0(ch0), .output_channel1(ch1),
        .output_channel0_load(ld0), .output_channel1_load(ld1),
        .output_channel0_offset_bin(ob0), .output_channel1_offset_bin(ob1), .irq(irq));
    dac_sink_model i_sink0 (.mclk(mclk), .sys_rst(sys_rst), .load(ld0), .code(ch0),
        .held(held0), .loads(loads0));
    dac_sink_model i_sink1 (.mclk(mclk), .sys_rst(sys_rst), .load(ld1), .code(ch1),
        .held(held1), .loads(loads1));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [5:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // Bounded wait for a converter load pulse on the chosen channel
    task automatic wait_load(input logic ch);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < 20 && !hit; n++) begin
            @(posedge mclk);
            #1;
            hit = ch ? (ld1 === 1'b1) : (ld0 === 1'b1);
        end
        chk("load seen", 16'h0001, {15'h0000, hit});
    endtask : wait_load

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        #200000;
        err_count++;
        results();
    end

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 6'h00;
        wdata = 16'h0000;
        trig_n = 1'b1;
        ser_valid = 1'b0;
        ser_chan = 1'b0;
        ser_code = 12'h000;
        err_count = 0;
        samples_checked = 0;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        chk("reset ch0", 16'h0000, {4'h0, ch0});
        chk("reset ch1", 16'h0000, {4'h0, ch1});
        chk("reset irq", 16'h0000, {15'h0000, irq});
        // Immediate direct mode, upper nibble must be dropped
        wr_reg(`OFS_CH0_CODE, 16'hFABC);
        chk("ch0 imm", 16'h0ABC, {4'h0, ch0});
        chk("ld0 imm", 16'h0001, {15'h0000, ld0});
        wr_reg(`OFS_CH1_CODE, 16'h3123);
        chk("ch1 imm", 16'h0123, {4'h0, ch1});
        // Nothing is taken while the clock enable is low
        @(posedge mclk);
        ce <= 1'b0;
        wr_reg(`OFS_CH0_CODE, 16'h0777);
        chk("ch0 frozen", 16'h0ABC, {4'h0, ch0});
        @(posedge mclk);
        ce <= 1'b1;
        // Strobe has no effect while updates are immediate
        wr_reg(`OFS_UPDATE, 16'h0000);
        chk("ld0 strobe imm", 16'h0000, {15'h0000, ld0});
        // Unipolar then bipolar two's complement, every boundary code on both channels
        for (int m = 0; m < 2; m++) begin
            c = '0;
            c.bipolar0 = m[0];
            c.twos0 = m[0];
            c.bipolar1 = m[0];
            c.twos1 = m[0];
            wr_reg(`OFS_CTRL, {9'h000, c});
            for (int i = 0; i < 4; i++) begin
                wr_reg(`OFS_CH0_CODE, {4'hF, codes[i]});
                wr_reg(`OFS_CH1_CODE, {4'hF, codes[i]});
                @(posedge mclk);
                #1;
                chk("ob0", {4'h0, codes[i] ^ {m[0], 11'h000}}, {4'h0, ob0});
                chk("ob1", {4'h0, codes[i] ^ {m[0], 11'h000}}, {4'h0, ob1});
            end
        end
        // Posted mode through the update strobe, with the interrupt unmasked
        c = '0;
        c.posted = 1'b1;
        wr_reg(`OFS_CTRL, {9'h000, c});
        wr_reg(`OFS_MASK, 16'h0001);
        wr_reg(`OFS_CH0_CODE, 16'h0111);
        wr_reg(`OFS_CH1_CODE, 16'h0222);
        chk("ch0 held", 16'h0FFF, {4'h0, ch0});
        chk("ch1 held", 16'h0FFF, {4'h0, ch1});
        wr_reg(`OFS_UPDATE, 16'h0000);
        chk("ch0 upd", 16'h0111, {4'h0, ch0});
        chk("ch1 upd", 16'h0222, {4'h0, ch1});
        chk("both ld", 16'h0003, {14'h0000, ld1, ld0});
        rd_reg(`OFS_STATUS, rv);
        chk("status req", 16'h0001, rv);
        chk("irq set", 16'h0001, {15'h0000, irq});
        rd_reg(`OFS_OUT_CLEAR, rv);
        rd_reg(`OFS_STATUS, rv);
        chk("status clr", 16'h0000, rv);
        chk("irq clr", 16'h0000, {15'h0000, irq});
        // Posted mode through the timer trigger falling edge
        wr_reg(`OFS_CH0_CODE, 16'h0333);
        @(posedge mclk);
        trig_n <= 1'b0;
        wait_load(1'b0);
        @(posedge mclk);
        trig_n <= 1'b1;
        chk("ch0 trig", 16'h0333, {4'h0, ch0});
        rd_reg(`OFS_STATUS, rv);
        chk("status trig", 16'h0001, rv);
        // Queued path: overfill, apply one word, flush
        c.path = dual_dac_pkg::PATH_FIFO;
        wr_reg(`OFS_CTRL, {9'h000, c});
        for (int i = 0; i < 9; i++) begin
            wr_reg(`OFS_CH0_CODE, 16'hF100 + 16'(i));
        end
        rd_reg(`OFS_FIFO_LEVEL, rv);
        chk("level full", 16'h0008, rv);
        rd_reg(`OFS_STATUS, rv);
        chk("overflow", 16'h0005, rv);
        wr_reg(`OFS_UPDATE, 16'h0000);
        chk("ch0 fifo", 16'h0100, {4'h0, ch0});
        rd_reg(`OFS_FIFO_LEVEL, rv);
        chk("level pop", 16'h0007, rv);
        wr_reg(`OFS_OUT_CLEAR, 16'h0000);
        rd_reg(`OFS_FIFO_LEVEL, rv);
        chk("level flush", 16'h0000, rv);
        rd_reg(`OFS_STATUS, rv);
        chk("status keep", 16'h0004, rv);
        wr_reg(`OFS_STATUS, 16'h0004);
        rd_reg(`OFS_STATUS, rv);
        chk("status w1c", 16'h0000, rv);
        // Immediate mode bypasses the queue even with the queued path chosen
        c.posted = 1'b0;
        wr_reg(`OFS_CTRL, {9'h000, c});
        wr_reg(`OFS_CH1_CODE, 16'h0456);
        chk("ch1 bypass", 16'h0456, {4'h0, ch1});
        rd_reg(`OFS_FIFO_LEVEL, rv);
        chk("level bypass", 16'h0000, rv);
        // Serial path: bus codes ignored, companion word reaches channel 1
        c.path = dual_dac_pkg::PATH_SERIAL;
        wr_reg(`OFS_CTRL, {9'h000, c});
        wr_reg(`OFS_CH0_CODE, 16'h0AAA);
        chk("ch0 serial", 16'h0100, {4'h0, ch0});
        @(posedge mclk);
        ser_chan <= 1'b1;
        ser_code <= 12'h5A5;
        ser_valid <= 1'b1;
        wait_load(1'b1);
        @(posedge mclk);
        ser_valid <= 1'b0;
        chk("ch1 serial", 16'h05A5, {4'h0, ch1});
        rd_reg(6'h3E, rv);
        chk("unmapped", 16'h0000, rv);
        chk("sink0", 16'h0100, {4'h0, held0});
        chk("sink1", 16'h05A5, {4'h0, held1});
        chk("loads0", 16'h000C, 16'(loads0));
        chk("loads1", 16'h000D, 16'(loads1));
        results();
    end
endmodule : dual_dac_write_update_control_tb_top

`default_nettype wire
